// ==== bcc_alu.sv ====
`timescale 1ns/1ps
`default_nettype none

module bcc_alu
  import bcc_pkg::*;
(
  input wire bcc_op_e op,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] mem_in,
  input wire logic [7:0] wreg_in,
  input wire bcc_flags_s flags_in,
  output bcc_res_s res
);

  // ==========================================================
  // combinational execute stage
  logic [7:0] lo_sum;
  logic [8:0] hi_sum;
  logic [7:0] inv_val;

  always_comb begin
    lo_sum = {4'h0, wreg_in[3:0]};
    hi_sum = {1'b0, wreg_in};
    inv_val = ~mem_in;
    res = '0;
    res.wreg = wreg_in;
    res.mem_data = mem_in;
    res.flags = flags_in;
    case (op)
      BCC_OP_BIT_CLR: begin
        // only the chosen bit drops; flags untouched
        res.mem_data = mem_in & ~(BCC_BYTE_ONE << bit_sel);
        res.mem_we = 1'b1;
      end
      BCC_OP_WDOG_CLR: begin
        res.wdog_clr = 1'b1;
        res.flags.tmo = 1'b0;
        res.flags.pdn = 1'b0;
      end
      BCC_OP_INV_MEM: begin
        res.mem_data = inv_val;
        res.mem_we = 1'b1;
        res.flags.z = (inv_val == BCC_BYTE_ZERO);
      end
      BCC_OP_INV_REG: begin
        res.wreg = inv_val;
        res.wreg_we = 1'b1;
        res.mem_we = 1'b0; // memory kept as is
        res.flags.z = (inv_val == BCC_BYTE_ZERO);
      end
      BCC_OP_DEC_ADJ: begin
        // low nibble first, its carry rolls into the high nibble
        if ((wreg_in[3:0] > BCC_NIB_MAX) || flags_in.aux) begin
          lo_sum = {4'h0, wreg_in[3:0]} + {4'h0, BCC_NIB_ADJ};
        end
        hi_sum = {1'b0, wreg_in[7:4], 4'h0} + {1'b0, lo_sum};
        if ((hi_sum[7:4] > BCC_NIB_MAX) || flags_in.c) begin
          hi_sum = hi_sum + {1'b0, BCC_NIB_ADJ, 4'h0};
        end
        res.mem_data = hi_sum[7:0];
        res.mem_we = 1'b1; // working register untouched
        // carry may only rise, keeps multi-byte sums going
        res.flags.c = flags_in.c | hi_sum[8];
      end
      default: begin
        res.mem_we = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

// ==== bcc_core.sv ====
// Overview of operation
// - bit clear forces one chosen data byte bit to 0, others kept.
// - watchdog clear resets counter, timeout and power-down flags only.
// - in-place complement inverts the byte, writes it back, updates zero.
// - complement-to-register puts inverted byte in working register, updates zero.
// - complement-to-register never writes the data byte.
// - decimal adjust writes its result to the data byte, not register.
// - decimal adjust turns a binary sum of BCD operands into BCD.
// - low nibble gets plus six when above nine or aux carry set.
// - high nibble gets plus six when above nine or carry set.
// - decimal adjust changes only the carry flag, reporting overflow.
`timescale 1ns/1ps
`default_nettype none

module bcc_core
  import bcc_pkg::*;
#(
  parameter int unsigned WDOG_W = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [WDOG_W-1:0] watchdog_counter,
  output logic timeout_flag,
  output logic power_down_flag
);

  // ==========================================================
  // state registers
  logic [7:0] wreg_reg, wreg_next;
  logic [7:0] mdat_reg, mdat_next;
  bcc_flags_s flg_reg, flg_next;
  logic [2:0] bsel_reg, bsel_next;
  logic [WDOG_W-1:0] wdog_reg, wdog_next;
  logic [31:0] rd_reg, rd_next;
  logic rdy_reg, rdy_next;
  logic err_reg, err_next;
  bcc_op_e op_reg, op_next;

  typedef enum logic [1:0] {
    BCC_ST_IDLE = 2'b01,
    BCC_ST_EXEC = 2'b10
  } bcc_state_e;
  bcc_state_e st_reg, st_next;

  bcc_res_s alu_res;
  logic wr_take, rd_take, hit;
  logic [2:0] cmd_op;

  // ==========================================================
  // execute datapath
  bcc_alu u_alu (
    .op(op_reg),
    .bit_sel(bsel_reg),
    .mem_in(mdat_reg),
    .wreg_in(wreg_reg),
    .flags_in(flg_reg),
    .res(alu_res)
  );

  // apb phase decode; access completes in the second cycle
  assign wr_take = psel && penable && pwrite && !rdy_reg;
  assign rd_take = psel && penable && !pwrite && !rdy_reg;
  assign hit = (paddr == BCC_OFS_CMD) || (paddr == BCC_OFS_OPER)
    || (paddr == BCC_OFS_WREG) || (paddr == BCC_OFS_STAT)
    || (paddr == BCC_OFS_MDAT);
  assign cmd_op = pwdata[BCC_CMD_OP_LSB +: 3];

  // ==========================================================
  // next state: bus writes, then execution results
  always_comb begin
    wreg_next = wreg_reg;
    mdat_next = mdat_reg;
    flg_next = flg_reg;
    bsel_next = bsel_reg;
    op_next = op_reg;
    st_next = st_reg;
    // free-running watchdog; overflow raises the timeout flag
    wdog_next = wdog_reg + {{(WDOG_W-1){1'b0}}, 1'b1};
    rdy_next = 1'b0;
    err_next = 1'b0;
    rd_next = rd_reg;
    if (psel && penable && !rdy_reg) begin
      rdy_next = 1'b1;
      err_next = !hit;
    end
    // command writes while an op runs are dropped and op results override bus writes; execution is one cycle
    if (wr_take && pstrb[0]) begin
      case (paddr)
        BCC_OFS_OPER: mdat_next = pwdata[7:0];
        BCC_OFS_WREG: wreg_next = pwdata[7:0];
        BCC_OFS_STAT: flg_next = pwdata[4:0];
        BCC_OFS_MDAT: mdat_next = pwdata[7:0];
        BCC_OFS_CMD: begin
          if (st_reg == BCC_ST_IDLE) begin
            op_next = bcc_op_e'(cmd_op);
            bsel_next = pwdata[BCC_CMD_BIT_LSB +: 3];
            st_next = BCC_ST_EXEC;
          end
        end
        default: begin
          err_next = 1'b1;
        end
      endcase
    end
    // overflow after the bus write so a status write cannot hide it
    if (&wdog_reg) begin
      flg_next.tmo = 1'b1;
    end
    if (rd_take) begin
      case (paddr)
        BCC_OFS_CMD: rd_next = {25'h0, bsel_reg, 1'b0, op_reg};
        BCC_OFS_OPER: rd_next = {24'h0, mdat_reg};
        BCC_OFS_WREG: rd_next = {24'h0, wreg_reg};
        BCC_OFS_STAT: rd_next = {26'h0, st_reg == BCC_ST_EXEC, flg_reg};
        BCC_OFS_MDAT: rd_next = {24'h0, mdat_reg};
        default: rd_next = 32'h0000_0000;
      endcase
    end
    case (st_reg)
      BCC_ST_IDLE: begin
        st_next = st_next;
      end
      BCC_ST_EXEC: begin
        // commit alu result; only written targets change
        if (alu_res.mem_we) begin
          mdat_next = alu_res.mem_data;
        end
        if (alu_res.wreg_we) begin
          wreg_next = alu_res.wreg;
        end
        flg_next.z = alu_res.flags.z;
        flg_next.c = alu_res.flags.c;
        flg_next.aux = alu_res.flags.aux;
        // the cleared counter cannot overflow, so clear wins here
        if (alu_res.wdog_clr) begin
          wdog_next = BCC_WDOG_ZERO[WDOG_W-1:0];
          flg_next.tmo = 1'b0;
          flg_next.pdn = 1'b0;
        end
        op_next = BCC_OP_NONE;
        st_next = BCC_ST_IDLE;
      end
      default: begin
        st_next = BCC_ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wreg_reg <= '0;
      mdat_reg <= '0;
      flg_reg <= '0;
      bsel_reg <= '0;
      wdog_reg <= '0;
      rd_reg <= '0;
      rdy_reg <= 1'b0;
      err_reg <= 1'b0;
      op_reg <= BCC_OP_NONE;
      st_reg <= BCC_ST_IDLE;
    end else begin
      wreg_reg <= wreg_next;
      mdat_reg <= mdat_next;
      flg_reg <= flg_next;
      bsel_reg <= bsel_next;
      wdog_reg <= wdog_next;
      rd_reg <= rd_next;
      rdy_reg <= rdy_next;
      err_reg <= err_next;
      op_reg <= op_next;
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign prdata = rd_reg;
  assign pready = rdy_reg;
  assign pslverr = err_reg;
  assign watchdog_counter = wdog_reg;
  assign timeout_flag = flg_reg.tmo;
  assign power_down_flag = flg_reg.pdn;

endmodule

`default_nettype wire

// ==== bcc_core_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker, sees only the top ports
module bcc_core_props #(parameter int unsigned WDOG_W = 16) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [WDOG_W-1:0] watchdog_counter,
  input wire logic timeout_flag,
  input wire logic power_down_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // watchdog clear command being taken on this edge
  logic wdclr;
  assign wdclr = psel && penable && !pready && pwrite && pstrb[0]
    && paddr == 12'h000 && pwdata[2:0] == 3'h2;
  chk_rdy_access: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  chk_rdy_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_err_map: assert property (pready |->
    pslverr == !(paddr[1:0] == 2'h0 && paddr <= 12'h010))
    else $error("error flag does not match map");
  chk_err_zero: assert property (pready && pslverr && !pwrite |->
    prdata == 32'h0) else $error("unmapped read not zero");
  chk_wdt_clear: assert property (wdclr |-> ##[1:3]
    (watchdog_counter == '0 && !timeout_flag && !power_down_flag))
    else $error("watchdog clear incomplete");
  chk_wdt_counts: assert property (watchdog_counter != '0 |->
    watchdog_counter == $past(watchdog_counter) + 1'h1)
    else $error("watchdog counter skipped");
  // status writes may also set the flags, so they are excused
  chk_to_wrap: assert property ($rose(timeout_flag) |->
    watchdog_counter < 2 || $past(psel && pwrite)
    || $past(psel && pwrite, 2)) else $error("timeout without wrap");
  chk_pd_sw: assert property ($rose(power_down_flag) |->
    $past(psel && pwrite) || $past(psel && pwrite, 2))
    else $error("power down flag rose by itself");
endmodule
`default_nettype wire

// ==== bcc_core_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module bcc_core_tb_top
  import bcc_pkg::*;
;
  // ==========================================================
  // signals, short watchdog so a wrap shows quickly
  localparam int unsigned TW = 6;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, to_flag, pd_flag;
  logic [TW-1:0] wdt;
  logic [7:0] rm, ra;
  logic [4:0] rs;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #2 pclk = ~pclk;
  bcc_core #(.WDOG_W(TW)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .watchdog_counter(wdt),
    .timeout_flag(to_flag), .power_down_flag(pd_flag));
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] got,
    input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic exec(input logic [2:0] op, input logic [2:0] b,
    input logic [7:0] m, input logic [7:0] a, input logic [4:0] st);
    apb(1'h1, BCC_OFS_OPER, {24'h0, m});
    apb(1'h1, BCC_OFS_WREG, {24'h0, a});
    apb(1'h1, BCC_OFS_STAT, {27'h0, st});
    apb(1'h1, BCC_OFS_CMD, {25'h0, b, 1'h0, op});
    apb(1'h0, BCC_OFS_MDAT, 32'h0);
    rm = rd[7:0];
    apb(1'h0, BCC_OFS_WREG, 32'h0);
    ra = rd[7:0];
    apb(1'h0, BCC_OFS_STAT, 32'h0);
    rs = rd[4:0];
  endtask
  // ==========================================================
  // scenarios
  task automatic t_bit_clr;
    for (int i = 0; i < 8; i++) begin
      exec(BCC_OP_BIT_CLR, 3'(i), 8'hFF, 8'h3C, 5'h17);
      chk("bclr mem", rm, 8'hFF & ~(8'h01 << i));
      chk("bclr flags", rs & 5'h17, 5'h17);
      chk("bclr pins", pd_flag, 1'h1);
      chk("bclr reg", ra, 8'h3C);
    end
  endtask
  task automatic t_inv_mem;
    exec(BCC_OP_INV_MEM, 3'h0, 8'hFF, 8'h11, 5'h00);
    chk("inv mem", {rm, 3'h0, rs[0]}, 12'h001);
    exec(BCC_OP_INV_MEM, 3'h0, 8'h5A, 8'h11, 5'h01);
    chk("inv mem2", {rm, 3'h0, rs[0]}, 12'hA50);
  endtask
  task automatic t_inv_reg;
    exec(BCC_OP_INV_REG, 3'h0, 8'hFF, 8'h77, 5'h00);
    chk("invr reg", {ra, 3'h0, rs[0]}, 12'h001);
    chk("invr mem", rm, 8'hFF);
    exec(BCC_OP_INV_REG, 3'h0, 8'h0F, 8'h00, 5'h01);
    chk("invr reg2", {ra, 3'h0, rs[0]}, 12'hF00);
    chk("invr mem2", rm, 8'h0F);
  endtask
  // sums of bcd pairs; third case has aux carry, fifth has carry
  task automatic t_dec_adj;
    logic [7:0] tab [6] = '{8'h15, 8'h0C, 8'h12, 8'hA2, 8'h31, 8'h9A};
    logic [8:0] t;
    logic [1:0] fl;
    for (int i = 0; i < 6; i++) begin
      fl = {i == 4, i == 2};
      t = {1'h0, tab[i]};
      if (t[3:0] > BCC_NIB_MAX || fl[0]) t = t + {5'h0, BCC_NIB_ADJ};
      if (t[7:4] > BCC_NIB_MAX || fl[1]) t = t + {1'h0, BCC_NIB_ADJ, 4'h0};
      exec(BCC_OP_DEC_ADJ, 3'h0, 8'h44, tab[i], {2'h0, fl[0], fl[1], 1'h1});
      chk("dadj mem", rm, t[7:0]);
      chk("dadj reg", ra, tab[i]);
      chk("dadj flags", rs[2:0], {fl[0], fl[1] | t[8], 1'h1});
    end
  endtask
  // counter is zero after the commit edge, then 11 edges of reads pass
  task automatic t_wdog;
    exec(BCC_OP_WDOG_CLR, 3'h0, 8'h21, 8'h43, 5'h1F);
    chk("wdog stat", {rm, ra, 3'h0, rs}, 24'h214307);
    chk("wdog pins", {to_flag, pd_flag}, 2'h0);
    chk("wdog count", wdt, 6'h0B);
    repeat (70) @(posedge pclk);
    chk("wdog wrap", to_flag, 1'h1);
  endtask
  // undecoded op must leave data, register and flags alone
  task automatic t_unmapped;
    exec(BCC_OP_NONE, 3'h0, 8'h5A, 8'hA5, 5'h07);
    chk("nop mem", rm, 8'h5A);
    chk("nop reg", {ra, 1'h0, rs[2:0]}, 12'hA57);
    apb(1'h0, 12'h014, 32'h0);
    chk("unmapped rd", {er, rd}, {1'h1, 32'h0});
    apb(1'h1, 12'h0FC, 32'hFF);
    chk("unmapped wr", er, 1'h1);
  endtask
  // ==========================================================
  // run control
  task automatic finish_test;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    finish_test;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    t_bit_clr;
    t_inv_mem;
    t_inv_reg;
    t_dec_adj;
    t_wdog;
    t_unmapped;
    finish_test;
  end
endmodule
bind bcc_core bcc_core_props #(.WDOG_W(WDOG_W)) u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .watchdog_counter(watchdog_counter),
  .timeout_flag(timeout_flag), .power_down_flag(power_down_flag));
`default_nettype wire

// ==== bcc_pkg.sv ====
package bcc_pkg;

  // ==========================================================
  // widths and constants
  localparam int unsigned BCC_DW = 8;
  localparam int unsigned BCC_AW = 8;
  localparam logic [3:0] BCC_NIB_MAX = 4'h9;
  localparam logic [3:0] BCC_NIB_ADJ = 4'h6;
  localparam logic [7:0] BCC_BYTE_ZERO = 8'h00;
  localparam logic [7:0] BCC_BYTE_ONE = 8'h01;
  localparam logic [15:0] BCC_WDOG_ZERO = 16'h0000;

  // ==========================================================
  // APB register map (byte addresses)
  localparam logic [11:0] BCC_OFS_CMD = 12'h000;
  localparam logic [11:0] BCC_OFS_OPER = 12'h004;
  localparam logic [11:0] BCC_OFS_WREG = 12'h008;
  localparam logic [11:0] BCC_OFS_STAT = 12'h00C;
  localparam logic [11:0] BCC_OFS_MDAT = 12'h010;

  // status register field positions
  localparam int unsigned BCC_ST_Z = 0;
  localparam int unsigned BCC_ST_C = 1;
  localparam int unsigned BCC_ST_AUX = 2;
  localparam int unsigned BCC_ST_TMO = 3;
  localparam int unsigned BCC_ST_PDN = 4;
  localparam int unsigned BCC_ST_BUSY = 5;

  // command register layout: op in [2:0], bit index in [6:4]
  localparam int unsigned BCC_CMD_OP_LSB = 0;
  localparam int unsigned BCC_CMD_BIT_LSB = 4;

  // ==========================================================
  // operations
  typedef enum logic [2:0] {
    BCC_OP_NONE = 3'h0,
    BCC_OP_BIT_CLR = 3'h1,
    BCC_OP_WDOG_CLR = 3'h2,
    BCC_OP_INV_MEM = 3'h3,
    BCC_OP_INV_REG = 3'h4,
    BCC_OP_DEC_ADJ = 3'h5
  } bcc_op_e;

  // status flags travel together
  typedef struct packed {
    logic pdn;
    logic tmo;
    logic aux;
    logic c;
    logic z;
  } bcc_flags_s;

  // datapath result from the alu module
  typedef struct packed {
    logic [7:0] mem_data;
    logic mem_we;
    logic [7:0] wreg;
    logic wreg_we;
    bcc_flags_s flags;
    logic wdog_clr;
  } bcc_res_s;

endpackage
